//--- hdl/mrps_consts.svh
// Constants of the reset and power-up sequencer: offsets, fields, resets, timing
`ifndef MRPS_CONSTS_SVH
`define MRPS_CONSTS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define MRPS_ADDR_W 8
`define MRPS_REG_CTRL1 8'h01
`define MRPS_CTRL1_RESET 8'h12
`define MRPS_CTRL1_WMASK 8'hD6
`define MRPS_BIT_INT_RST 0
`define MRPS_BIT_PROT_SUPPLY 4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MRPS_CLK_MHZ 250
`define MRPS_REF_TIME_NS 5000
`define MRPS_POR_TIME_US 128
`define MRPS_KEYF_TIME_US 12700
`define MRPS_UV_TIME_US 10
`define MRPS_REF_CYC ((`MRPS_REF_TIME_NS * `MRPS_CLK_MHZ + 999) / 1000)
`define MRPS_POR_CYC (`MRPS_POR_TIME_US * `MRPS_CLK_MHZ)
`define MRPS_KEYF_CYC (`MRPS_KEYF_TIME_US * `MRPS_CLK_MHZ)
`define MRPS_UV_CYC (`MRPS_UV_TIME_US * `MRPS_CLK_MHZ)

`endif

//--- hdl/mrps_pin_sync.sv
// Three-stage input synchroniser, change taken once stages two and three agree
module mrps_pin_sync #(
  parameter int W = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  // ------------------------------------------------------------
  // One chain per bit
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q, s2_q, s3_q;
      // First stage feeds only the second, to contain metastability
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Accept only a level seen twice in a row
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2_q == s3_q) begin
          sync_o[g] <= s3_q;
        end
      end
    end
  endgenerate

endmodule // mrps_pin_sync

//--- hdl/mrps_pkg.sv
// Types of the reset and power-up sequencer
package mrps_pkg;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP, ST_REF, ST_KEYFILT, ST_PREREG, ST_REGRAMP, ST_POR, ST_RUN, ST_WDPULSE, ST_OV
  } mrps_state_e;

  // ------------------------------------------------------------
  // Control register 1 layout, msb first
  // ------------------------------------------------------------
  typedef struct packed {
    logic power_relay_en;
    logic self_test_enable;
    logic unused5;
    logic prot_supply_en;
    logic unused3;
    logic batsw_en;
    logic tach_en;
    logic int_rst;
  } mrps_ctrl_s;

  // Analog comparator levels after synchronising
  typedef struct packed {
    logic key_on;
    logic vpp_sense_ok;
    logic vcc_above_por;
    logic vcc_uv;
    logic batt_ov;
  } mrps_pins_s;

  // Enables towards the analog blocks
  typedef struct packed {
    logic ref_en;
    logic core_power_on_reset_n;
    logic prereg_en;
    logic vcc_en;
    logic protected_sensor_supply;
    logic batsw_buffer_power;
    logic drivers_en;
  } mrps_enables_s;

endpackage

//--- hdl/mrps_top.sv
// Reset generator and power-up sequencer for the host controller
`include "mrps_consts.svh"

module mrps_top import mrps_pkg::*; #(
  parameter logic [31:0] POR_CYC = 32'(`MRPS_POR_CYC),
  parameter logic [31:0] KEYF_CYC = 32'(`MRPS_KEYF_CYC),
  parameter logic [31:0] HOLD_CYC = 32'(`MRPS_POR_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic key_on_i,
  input wire logic vpp_sense_ok_i,
  input wire logic vcc_above_por_i,
  input wire logic vcc_uv_i,
  input wire logic batt_ov_i,
  input wire logic wd_timeout_i,
  input wire logic reg_wr_i,
  input wire logic [`MRPS_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic mcu_reset_out_n_o,
  output logic mcu_reset_out_n_oe_n_o,
  output logic internal_reset_o,
  output mrps_enables_s enables_o,
  output mrps_ctrl_s ctrl_o
);

  localparam logic [31:0] REF_CYC = 32'(`MRPS_REF_CYC);
  localparam logic [31:0] UV_CYC = 32'(`MRPS_UV_CYC);

  mrps_pins_s pins;
  mrps_state_e state_q, state_d;
  logic [31:0] cnt_q;
  logic [31:0] uv_cnt_q;
  logic uv_filt;
  logic ctrl_wr;
  mrps_ctrl_s ctrl_q;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  mrps_pin_sync #(
    .W(5)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i({key_on_i, vpp_sense_ok_i, vcc_above_por_i, vcc_uv_i, batt_ov_i}),
    .sync_o(pins)
  );

  // ------------------------------------------------------------
  // Undervoltage filter
  // ------------------------------------------------------------
  // Counts only in ST_RUN and ST_WDPULSE; short dips shorter than the filter are ignored
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      uv_cnt_q <= 32'h0000_0000;
    end else if (pins.vcc_uv && state_q inside {ST_RUN, ST_WDPULSE}) begin
      if (!uv_filt) begin
        uv_cnt_q <= uv_cnt_q + 32'h0000_0001;
      end
    end else begin
      uv_cnt_q <= 32'h0000_0000;
    end
  end
  assign uv_filt = (uv_cnt_q >= UV_CYC);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP: begin
        state_d = ST_REF;
      end
      ST_REF: begin
        if (cnt_q == REF_CYC - 32'h1) state_d = ST_KEYFILT;
      end
      ST_KEYFILT: begin
        if (cnt_q == KEYF_CYC - 32'h1) state_d = ST_PREREG;
      end
      ST_PREREG: begin
        if (pins.vpp_sense_ok) state_d = ST_REGRAMP;
      end
      ST_REGRAMP: begin
        if (pins.vcc_above_por) state_d = ST_POR;
      end
      ST_POR: begin
        if (!pins.vcc_above_por) state_d = ST_REGRAMP;
        else if (cnt_q == POR_CYC - 32'h1) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (uv_filt) state_d = ST_REGRAMP;
        else if (wd_timeout_i) state_d = ST_WDPULSE;
      end
      ST_WDPULSE: begin
        if (uv_filt) state_d = ST_REGRAMP;
        else if (cnt_q == HOLD_CYC - 32'h1) state_d = ST_RUN;
      end
      ST_OV: begin
        if (!pins.batt_ov) state_d = ST_PREREG;
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
    // Key loss puts the part to sleep; overvoltage wins once the core is alive
    if (!pins.key_on) begin
      state_d = ST_SLEEP;
    end else if (pins.batt_ov && !(state_q inside {ST_SLEEP, ST_REF})) begin
      state_d = ST_OV;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared delay counter, restarted on every state change
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0000_0000;
    end else if (state_d != state_q) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Control register 1
  // ------------------------------------------------------------
  assign ctrl_wr = reg_wr_i && (reg_addr_i == `MRPS_REG_CTRL1);

  // Held at default while the host is in a power-related reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `MRPS_CTRL1_RESET;
    end else if (!(state_q inside {ST_RUN, ST_WDPULSE})) begin
      ctrl_q <= `MRPS_CTRL1_RESET;
    end else if (ctrl_wr && reg_wdata_i[`MRPS_BIT_INT_RST]) begin
      ctrl_q <= `MRPS_CTRL1_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata_i & `MRPS_CTRL1_WMASK;
    end
  end

  // Internal reset pulse for the rest of the chip; the pin is left alone
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      internal_reset_o <= 1'b0;
    end else begin
      internal_reset_o <= ctrl_wr && reg_wdata_i[`MRPS_BIT_INT_RST]
        && (state_q inside {ST_RUN, ST_WDPULSE});
    end
  end

  // Read data registered, unmapped addresses read zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      ctrl_o <= `MRPS_CTRL1_RESET;
    end else begin
      reg_rdata_o <= (reg_addr_i == `MRPS_REG_CTRL1) ? ctrl_q : 8'h00;
      ctrl_o <= ctrl_q;
    end
  end

  // ------------------------------------------------------------
  // Pin and enable outputs
  // ------------------------------------------------------------
  // Open drain: data is always low, the enable alone pulls the line
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mcu_reset_out_n_o <= 1'b0;
      mcu_reset_out_n_oe_n_o <= 1'b0;
    end else begin
      mcu_reset_out_n_o <= 1'b0;
      mcu_reset_out_n_oe_n_o <= (state_q == ST_RUN);
    end
  end

  // Enables follow the state one cycle late
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enables_o <= '0;
    end else begin
      enables_o.ref_en <= (state_q != ST_SLEEP);
      enables_o.core_power_on_reset_n <= !(state_q inside {ST_SLEEP, ST_REF});
      enables_o.prereg_en <= state_q inside {ST_PREREG, ST_REGRAMP, ST_POR, ST_RUN,
        ST_WDPULSE};
      enables_o.vcc_en <= state_q inside {ST_REGRAMP, ST_POR, ST_RUN, ST_WDPULSE};
      enables_o.batsw_buffer_power <= state_q inside {ST_REGRAMP, ST_POR, ST_RUN,
        ST_WDPULSE};
      enables_o.protected_sensor_supply <= ctrl_q.prot_supply_en && (state_q inside
        {ST_REGRAMP, ST_POR, ST_RUN, ST_WDPULSE});
      enables_o.drivers_en <= (state_q == ST_RUN);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_od_data_low: assert property (mcu_reset_out_n_o == 1'b0)
    else $error("reset pin data not low");
  chk_por_hold: assert property ($rose(state_q == ST_POR) |->
    mcu_reset_out_n_oe_n_o == 1'b0 [*8])
    else $error("reset released early after power-on threshold");
  chk_por_len: assert property ((state_q == ST_POR) && (state_d == ST_RUN) |->
    cnt_q == POR_CYC - 32'h1)
    else $error("power-on delay count wrong");
  chk_wd_pulse: assert property ((state_q == ST_RUN) && wd_timeout_i && pins.key_on
    && !pins.batt_ov && !uv_filt |-> ##2 !mcu_reset_out_n_oe_n_o)
    else $error("watchdog did not pull reset");
  chk_sleep_por: assert property ($past(state_q) == ST_SLEEP && state_q != ST_SLEEP
    |-> state_q == ST_REF)
    else $error("wake skipped power-on sequence");
  chk_int_rst_pin: assert property (internal_reset_o && $past(state_q) == ST_RUN
    && state_q == ST_RUN |-> $stable(mcu_reset_out_n_oe_n_o))
    else $error("internal reset moved the pin");
  chk_int_rst_clr: assert property (internal_reset_o |-> ctrl_q == `MRPS_CTRL1_RESET)
    else $error("internal reset left register dirty");
  chk_zero_noop: assert property (ctrl_wr && !reg_wdata_i[0] |=> !internal_reset_o)
    else $error("zero write caused internal reset");
  chk_ov_off: assert property (state_q == ST_OV |=> enables_o.prereg_en == 1'b0
    && enables_o.vcc_en == 1'b0 && enables_o.drivers_en == 1'b0)
    else $error("enables on during overvoltage");
  chk_uv_reset: assert property (state_q == ST_RUN && uv_filt && pins.key_on
    && !pins.batt_ov |=> state_q == ST_REGRAMP)
    else $error("filtered undervoltage ignored");
  chk_ref_delay: assert property ($rose(state_q == ST_REF) |->
    (state_q == ST_REF || !pins.key_on) [*4])
    else $error("core reset lifted too soon");
  chk_ctrl_fields: assert property (ctrl_q.unused5 == 1'b0 && ctrl_q.unused3 == 1'b0
    && ctrl_q.int_rst == 1'b0)
    else $error("reserved or self-clearing bit set");
  chk_prot_off: assert property (!ctrl_q.prot_supply_en |=> !enables_o.protected_sensor_supply)
    else $error("protected supply on while disabled");
  chk_ctrl_default: assert property (state_q inside {ST_OV, ST_REGRAMP} |=>
    ctrl_q == `MRPS_CTRL1_RESET)
    else $error("control not defaulted by reset");

  cov_release: cover property (state_q == ST_POR ##1 state_q == ST_RUN);
  cov_wd: cover property (state_q == ST_WDPULSE ##1 state_q == ST_RUN);
  cov_ov: cover property (state_q == ST_OV ##1 state_q == ST_PREREG);
  cov_int_rst: cover property (internal_reset_o);

endmodule // mrps_top

//--- verif/mrps_host_model.sv
// Host-side model: pulled-up reset line and the supply ramps seen by the sequencer
module mrps_host_model import mrps_pkg::*; (
  input wire logic clk_sys_i,
  input wire mrps_enables_s enables_i,
  input wire logic mcu_reset_out_n_i,
  input wire logic mcu_reset_out_n_oe_n_i,
  output logic vpp_sense_ok_o,
  output logic vcc_above_por_o,
  output logic reset_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int vpp_cnt = 0;
  int vcc_cnt = 0;
  // Pull-up to the host rail wins only while the pin is released
  assign reset_line_o = mcu_reset_out_n_oe_n_i ? 1'b1 : mcu_reset_out_n_i;
  // Ramps as fixed settle counts; they drop at once when disabled, so no stale good level
  always @(negedge clk_sys_i) begin
    vpp_cnt <= (enables_i.prereg_en === 1'b1) ? vpp_cnt + 1 : 0;
    vcc_cnt <= (enables_i.vcc_en === 1'b1) ? vcc_cnt + 1 : 0;
  end
  assign vpp_sense_ok_o = vpp_cnt >= 8;
  assign vcc_above_por_o = vcc_cnt >= 12;
endmodule // mrps_host_model

//--- verif/mrps_top_test.sv
// Self-checking bench of the reset and power-up sequencer
module mrps_top_test import mrps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Shortened counts, fixed ones as documented
  // ------------------------------------------------------------
  localparam int POR_N = 40;
  localparam int KEYF_N = 60;
  localparam int HOLD_N = 20;
  localparam int REF_N = 1250;
  localparam int UV_N = 2500;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic key_on_i = 1'b0;
  logic vcc_uv_i = 1'b0;
  logic batt_ov_i = 1'b0;
  logic wd_timeout_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic vpp_sense_ok_i;
  logic vcc_above_por_i;
  logic [7:0] reg_rdata_o;
  logic mcu_reset_out_n_o;
  logic mcu_reset_out_n_oe_n_o;
  logic internal_reset_o;
  logic reset_line;
  logic line_q = 1'b0;
  mrps_enables_s enables_o;
  mrps_ctrl_s ctrl_o;
  int miscompares = 0;
  int cmp_count = 0;
  int int_rst_cnt = 0;
  int fall_cnt = 0;
  int n;

  always #2 clk_sys_i = ~clk_sys_i;

  mrps_top #(.POR_CYC(32'(POR_N)), .KEYF_CYC(32'(KEYF_N)), .HOLD_CYC(32'(HOLD_N))) u_mrps_top (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .key_on_i(key_on_i),
    .vpp_sense_ok_i(vpp_sense_ok_i), .vcc_above_por_i(vcc_above_por_i),
    .vcc_uv_i(vcc_uv_i), .batt_ov_i(batt_ov_i), .wd_timeout_i(wd_timeout_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .mcu_reset_out_n_o(mcu_reset_out_n_o),
    .mcu_reset_out_n_oe_n_o(mcu_reset_out_n_oe_n_o), .internal_reset_o(internal_reset_o),
    .enables_o(enables_o), .ctrl_o(ctrl_o));

  mrps_host_model u_mrps_host_model (
    .clk_sys_i(clk_sys_i), .enables_i(enables_o), .mcu_reset_out_n_i(mcu_reset_out_n_o),
    .mcu_reset_out_n_oe_n_i(mcu_reset_out_n_oe_n_o), .vpp_sense_ok_o(vpp_sense_ok_i),
    .vcc_above_por_o(vcc_above_por_i), .reset_line_o(reset_line));

  // Event counters, so short pulses are never missed by sparse sampling
  always @(posedge clk_sys_i) begin
    if (internal_reset_o === 1'b1) int_rst_cnt++;
    if (line_q === 1'b1 && reset_line === 1'b0) fall_cnt++;
    line_q <= reset_line;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return 32'(v >= lo && v <= hi);
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return reset_line;
      1: return enables_o.ref_en;
      2: return enables_o.core_power_on_reset_n;
      3: return enables_o.prereg_en;
      4: return enables_o.vcc_en;
      default: return vcc_above_por_i;
    endcase
  endfunction
  // Bounded wait; running out counts a mismatch and closes the run
  task automatic wait_val(input int k, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (sig(k) !== v && cnt < lim) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    if (sig(k) !== v) begin
      miscompares++;
      $display("Error wait on signal %0d expected %0b", k, v);
      test_done();
    end
  endtask
  // Both accesses start and end at a falling edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i = a;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask
  task automatic power_up();
    key_on_i = 1'b1;
    wait_val(1, 1'b1, 20, n);
    wait_val(2, 1'b1, REF_N + 20, n);
    check("ref delay", inr(n, REF_N - 1, REF_N + 1), 32'h1);
    wait_val(3, 1'b1, KEYF_N + 20, n);
    check("key filter", inr(n, KEYF_N - 1, KEYF_N + 1), 32'h1);
    wait_val(4, 1'b1, 20, n);
    check("psupply on", 32'(enables_o.protected_sensor_supply), 32'h1);
    check("batsw power", 32'(enables_o.batsw_buffer_power), 32'h1);
    wait_val(5, 1'b1, 40, n);
    check("line at por", 32'(reset_line), 32'h0);
    wait_val(0, 1'b1, POR_N + 20, n);
    check("por delay", inr(n, POR_N, POR_N + 8), 32'h1);
    $display("test power up done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check("line in reset", 32'(reset_line), 32'h0);
    check("pin data", 32'(mcu_reset_out_n_o), 32'h0);
    check("enables", 32'(enables_o), 32'h0);
    check("ctrl reset", 32'(ctrl_o), 32'h12);
    reg_write(8'h01, 8'h00);
    reg_read(8'h01, d);
    check("early write", 32'(d), 32'h12);
    power_up();
    // Register access, mask, internal reset
    reg_read(8'h01, d);
    check("ctrl read", 32'(d), 32'h12);
    check("drivers run", 32'(enables_o.drivers_en), 32'h1);
    reg_write(8'h01, 8'hFE);
    reg_read(8'h01, d);
    check("write mask", 32'(d), 32'hD6);
    check("ctrl copy", 32'(ctrl_o), 32'hD6);
    reg_read(8'h05, d);
    check("unmapped", 32'(d), 32'h0);
    reg_write(8'h01, 8'h02);
    reg_read(8'h01, d);
    check("psupply bit", 32'(d), 32'h02);
    @(negedge clk_sys_i);
    check("psupply off", 32'(enables_o.protected_sensor_supply), 32'h0);
    check("no int reset", 32'(int_rst_cnt), 32'h0);
    reg_write(8'h01, 8'h01);
    repeat (3) @(negedge clk_sys_i);
    check("int reset pulse", 32'(int_rst_cnt), 32'h1);
    reg_read(8'h01, d);
    check("int reset value", 32'(d), 32'h12);
    check("psupply back", 32'(enables_o.protected_sensor_supply), 32'h1);
    check("line kept", 32'(fall_cnt), 32'h0);
    $display("test registers done");
    // Watchdog pulse keeps the control bits
    reg_write(8'h01, 8'h02);
    wd_timeout_i = 1'b1;
    @(negedge clk_sys_i);
    wd_timeout_i = 1'b0;
    wait_val(0, 1'b0, 10, n);
    wait_val(0, 1'b1, HOLD_N + 10, n);
    check("wd pulse", inr(n, HOLD_N - 1, HOLD_N + 1), 32'h1);
    reg_read(8'h01, d);
    check("wd keeps ctrl", 32'(d), 32'h02);
    $display("test watchdog done");
    // Undervoltage shorter, then longer, than the filter
    vcc_uv_i = 1'b1;
    repeat (UV_N - 100) @(negedge clk_sys_i);
    vcc_uv_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    check("short uv", 32'(fall_cnt), 32'h1);
    vcc_uv_i = 1'b1;
    wait_val(0, 1'b0, UV_N + 20, n);
    check("uv filter", inr(n, UV_N, UV_N + 8), 32'h1);
    vcc_uv_i = 1'b0;
    wait_val(0, 1'b1, POR_N + 40, n);
    reg_read(8'h01, d);
    check("uv default", 32'(d), 32'h12);
    $display("test undervoltage done");
    // Overvoltage shuts off all but the references and core, then restarts
    reg_write(8'h01, 8'h02);
    batt_ov_i = 1'b1;
    wait_val(0, 1'b0, 10, n);
    repeat (2) @(negedge clk_sys_i);
    // Core and references stay alive so the end of overvoltage is still seen
    check("ov enables", 32'(enables_o) & 32'h1F, 32'h0);
    repeat (20) @(negedge clk_sys_i);
    check("ov held", 32'(enables_o) & 32'h1F, 32'h0);
    batt_ov_i = 1'b0;
    wait_val(0, 1'b1, POR_N + 80, n);
    reg_read(8'h01, d);
    check("ov default", 32'(d), 32'h12);
    $display("test overvoltage done");
    // Sleep, then a second full power-on
    key_on_i = 1'b0;
    wait_val(0, 1'b0, 10, n);
    wait_val(1, 1'b0, 10, n);
    check("sleep enables", 32'(enables_o), 32'h0);
    repeat (10) @(negedge clk_sys_i);
    power_up();
    test_done();
  end
endmodule // mrps_top_test
